// ---- design/itd_exec.sv ----
// Executor for one periodic interrupt transfer descriptor.
// Assumes software loads the descriptor image and a packet engine answers
// each transaction with done or fatal; all on ref_clk.
// The interval code sits in the low byte of the third descriptor word.
// That word is not part of the 64-bit image, so it comes in on its own pins.
// It is taken with the same load strobe as the image.
// Sharing bits with the byte count would tie the poll rate to the length.
//
// The microframe length is a parameter so a bench can shorten it.
// Hardware keeps the default.
`timescale 1ns/1ps
module itd_exec
	import itd_pkg::*;
#(
	parameter int UFRAME_CYC = UFRAME_CYCLES
)
(
	input  wire logic            ref_clk,
	input  wire logic            rst_n,
	input  wire logic            desc_load,
	input  wire logic [63:0]     desc_in,
	input  wire logic [7:0]      desc_poll_in,
	input  wire logic            txn_done,
	input  wire logic [10:0]     txn_xfer_bytes,
	input  wire logic            txn_fatal,
	output itd_pkg::itd_txn_t    txn_r,
	output logic                 txn_req_r,
	output logic                 desc_valid_r,
	output logic                 desc_done_r,
	output logic                 desc_error_r,
	output logic [14:0]          bytes_left_r
);
	import itd_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_ISSUE,
		ST_BUSY
	} itd_state_t;

	itd_state_t  state_r;
	logic [63:0] desc_r;
	itd_fields_t fields;
	logic [16:0] uframe_cnt_r;
	logic        uframe_tick;
	logic [7:0]  poll_cnt_r;
	logic [7:0]  period_uf;
	logic        run_ok;
	logic [4:0]  poll_code_r;

	itd_decode u_dec (
		.desc   (desc_r),
		.fields (fields)
	);

	// Interval code, captured with the image
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_code_r <= 5'h00;
		end else if (desc_load) begin
			poll_code_r <= desc_poll_in[IVL_HI:IVL_LO];
		end
	end

	// 2 ms is 16 microframes = 2^(5-1); highest set bit picks the rate
	// Code zero is treated as b=4, so the period never collapses to nothing
	always_comb begin
		if (poll_code_r[4])      period_uf = 8'h00; // 256 wraps, counter handles
		else if (poll_code_r[3]) period_uf = 8'h80;
		else if (poll_code_r[2]) period_uf = 8'h40;
		else if (poll_code_r[1]) period_uf = 8'h20;
		else if (poll_code_r[0]) period_uf = 8'h10;
		else                     period_uf = 8'h08;
	end

	// Oversized total or bad token never reaches the bus
	assign run_ok = fields.is_interrupt
		&& (fields.transfer_byte_count <= MAX_TOTAL_BYTES)
		&& (fields.pid != ITD_PID_NONE);

	// Microframe tick divider
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			uframe_cnt_r <= 17'h00000;
		end else if (uframe_cnt_r == 17'(UFRAME_CYC - 1)) begin
			uframe_cnt_r <= 17'h00000;
		end else begin
			uframe_cnt_r <= uframe_cnt_r + 17'h00001;
		end
	end
	assign uframe_tick = (uframe_cnt_r == 17'(UFRAME_CYC - 1));

	// Poll interval counter, restarted on load
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_cnt_r <= 8'h00;
		end else if (desc_load || (uframe_tick && poll_cnt_r == period_uf - 8'h01)) begin
			poll_cnt_r <= 8'h00;
		end else if (uframe_tick) begin
			poll_cnt_r <= poll_cnt_r + 8'h01;
		end
	end

	// Descriptor image; valid bit is the only field hardware writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			desc_r <= 64'h0000_0000_0000_0000;
		end else if (desc_load) begin
			desc_r <= desc_in;
		end else if ((state_r == ST_BUSY && txn_fatal) ||
			(state_r == ST_BUSY && txn_done && bytes_left_r <= 15'(txn_xfer_bytes)) ||
			(state_r == ST_WAIT && !run_ok)) begin
			desc_r[VALID_POS] <= 1'b0;
		end
	end

	// Execution sequencer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= ST_IDLE;
			txn_r        <= '0;
			txn_req_r    <= 1'b0;
			bytes_left_r <= 15'h0000;
			desc_done_r  <= 1'b0;
			desc_error_r <= 1'b0;
		end else begin
			txn_req_r   <= 1'b0;
			desc_done_r <= 1'b0;
			if (desc_load) begin
				desc_error_r <= 1'b0;
				state_r      <= desc_in[VALID_POS] ? ST_WAIT : ST_IDLE;
				bytes_left_r <= desc_in[CNT_HI:CNT_LO];
			end else begin
				unique case (state_r)
					ST_IDLE: begin
						state_r <= ST_IDLE;
					end
					ST_WAIT: begin
						if (!fields.valid) begin
							state_r <= ST_IDLE;
						end else if (!run_ok) begin
							desc_error_r <= 1'b1;
							state_r      <= ST_IDLE;
						end else if (uframe_tick && poll_cnt_r == period_uf - 8'h01) begin
							state_r <= ST_ISSUE;
						end
					end
					ST_ISSUE: begin
						txn_r.addr  <= fields.target_function_address;
						txn_r.endp  <= fields.endpoint_number;
						txn_r.pid   <= fields.pid;
						txn_r.speed <= fields.speed;
						txn_r.bytes <= (bytes_left_r > 15'(fields.max_packet_bytes)) ?
							fields.max_packet_bytes : bytes_left_r[10:0];
						txn_req_r   <= 1'b1;
						state_r     <= ST_BUSY;
					end
					ST_BUSY: begin
						if (txn_fatal) begin
							desc_error_r <= 1'b1;
							state_r      <= ST_IDLE;
						end else if (txn_done) begin
							if (bytes_left_r <= 15'(txn_xfer_bytes)) begin
								bytes_left_r <= 15'h0000;
								desc_done_r  <= 1'b1;
								state_r      <= ST_IDLE;
							end else begin
								bytes_left_r <= bytes_left_r - 15'(txn_xfer_bytes);
								state_r      <= ST_WAIT;
							end
						end
					end
				endcase
			end
		end
	end

	// Valid flag mirrored as a registered output
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			desc_valid_r <= 1'b0;
		end else begin
			desc_valid_r <= desc_load ? desc_in[VALID_POS] :
				(desc_r[VALID_POS] && !(state_r == ST_BUSY && (txn_fatal ||
				(txn_done && bytes_left_r <= 15'(txn_xfer_bytes))))
				&& !(state_r == ST_WAIT && !run_ok));
		end
	end
endmodule : itd_exec

// ---- design/itd_pkg.sv ----
// Package for the interrupt transfer descriptor decoder and executor.
// Assumes a single 125 MHz clock domain and a 64-bit descriptor image.
package itd_pkg;

	// Descriptor field positions
	localparam int ADDR_HI      = 41;
	localparam int ADDR_LO      = 35;
	localparam int EP_UP_HI     = 34;
	localparam int EP_UP_LO     = 32;
	localparam int EP_LSB_POS   = 31;
	localparam int MPS_HI       = 28;
	localparam int MPS_LO       = 18;
	localparam int CNT_HI       = 17;
	localparam int CNT_LO       = 3;
	localparam int VALID_POS    = 0;
	localparam int IVL_HI       = 7;
	localparam int IVL_LO       = 3;
	localparam int SPEED_HI     = 49;
	localparam int SPEED_LO     = 48;
	localparam int SPLIT_POS    = 46;
	localparam int TTYPE_HI     = 45;
	localparam int TTYPE_LO     = 44;
	localparam int TOKEN_HI     = 43;
	localparam int TOKEN_LO     = 42;

	// Codes
	localparam logic [1:0] TTYPE_INTR  = 2'h3;
	localparam logic [1:0] TOKEN_OUT   = 2'h0;
	localparam logic [1:0] TOKEN_IN    = 2'h1;
	localparam logic [1:0] SPEED_LOW   = 2'h2;
	localparam logic [1:0] SPEED_FULL  = 2'h0;

	// Limits
	localparam logic [14:0] MAX_TOTAL_BYTES = 15'h1000;

	// Timing: one microframe is 125 us
	localparam int CLK_MHZ         = 125;
	localparam int UFRAME_NS       = 125000;
	localparam int UFRAME_CYCLES   = UFRAME_NS * CLK_MHZ / 1000;

	typedef enum logic [1:0] {
		ITD_SPD_HIGH,
		ITD_SPD_FULL,
		ITD_SPD_LOW
	} itd_speed_t;

	typedef enum logic [1:0] {
		ITD_PID_OUT,
		ITD_PID_IN,
		ITD_PID_NONE
	} itd_pid_t;

	// Decoded descriptor fields
	typedef struct packed {
		logic [6:0]  target_function_address;
		logic [3:0]  endpoint_number;
		logic [10:0] max_packet_bytes;
		logic [14:0] transfer_byte_count;
		logic [4:0]  poll_code;
		itd_speed_t  speed;
		itd_pid_t    pid;
		logic        is_interrupt;
		logic        valid;
	} itd_fields_t;

	// Transaction request to the packet engine
	typedef struct packed {
		logic [6:0]  addr;
		logic [3:0]  endp;
		itd_pid_t    pid;
		itd_speed_t  speed;
		logic [10:0] bytes;
	} itd_txn_t;

endpackage : itd_pkg

// ---- design/itd_decode.sv ----
// Field decoder for the interrupt transfer descriptor image.
// Assumes a static 64-bit descriptor word; purely combinational.
`timescale 1ns/1ps
module itd_decode
	import itd_pkg::*;
(
	input  wire logic [63:0] desc,
	output itd_pkg::itd_fields_t fields
);
	// Reserved bits 30:29 and 2:1 are never looked at
	always_comb begin
		fields.target_function_address = desc[ADDR_HI:ADDR_LO];
		fields.endpoint_number         = {desc[EP_UP_HI:EP_UP_LO], desc[EP_LSB_POS]};
		fields.max_packet_bytes        = desc[MPS_HI:MPS_LO];
		fields.transfer_byte_count     = desc[CNT_HI:CNT_LO];
		fields.poll_code               = 5'h00; // Interval lives in the third word, not here
		fields.is_interrupt            = (desc[TTYPE_HI:TTYPE_LO] == TTYPE_INTR);
		fields.valid                   = desc[VALID_POS];
		// Split bit picks high speed or translator speed
		if (!desc[SPLIT_POS]) begin
			fields.speed = ITD_SPD_HIGH;
		end else if (desc[SPEED_HI:SPEED_LO] == SPEED_LOW) begin
			fields.speed = ITD_SPD_LOW;
		end else begin
			fields.speed = ITD_SPD_FULL;
		end
		unique case (desc[TOKEN_HI:TOKEN_LO])
			TOKEN_OUT: fields.pid = ITD_PID_OUT;
			TOKEN_IN:  fields.pid = ITD_PID_IN;
			default:   fields.pid = ITD_PID_NONE;
		endcase
	end
endmodule : itd_decode

// ---- tb/itd_exec_checker.sv ----
// Port checker for the descriptor executor.
// Bound to itd_exec; one ref_clk domain.
`timescale 1ns/1ps
module itd_exec_checker
	import itd_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        desc_load,
	input wire logic [63:0] desc_in,
	input itd_pkg::itd_txn_t txn_r,
	input wire logic        txn_req_r,
	input wire logic        desc_valid_r,
	input wire logic        desc_done_r,
	input wire logic        desc_error_r,
	input wire logic [14:0] bytes_left_r
);
	logic [63:0] img_r;
	logic [10:0] mps;
	// Copy of the loaded image, so fields are judged against it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			img_r <= 64'h0;
		else if (desc_load)
			img_r <= desc_in;
	end
	assign mps = img_r[28:18];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_addr_taken: assert property (txn_req_r |-> txn_r.addr == img_r[41:35])
		else $error("token address wrong");
	chk_endp_join: assert property (txn_req_r |-> txn_r.endp == img_r[34:31])
		else $error("endpoint wrong");
	chk_pkt_limit: assert property (txn_req_r |->
		txn_r.bytes == ((bytes_left_r < 15'(mps)) ? bytes_left_r[10:0] : mps))
		else $error("packet size wrong");
	chk_load_count: assert property (desc_load && desc_in[0] && desc_in[45:44] == 2'h3 && !desc_in[43]
		&& desc_in[17:3] <= 15'h1000 |=> desc_valid_r && bytes_left_r == img_r[17:3])
		else $error("count not taken");
	chk_type_refuse: assert property (desc_load && desc_in[0] && desc_in[45:44] != 2'h3
		|-> ##2 desc_error_r && !desc_valid_r)
		else $error("wrong type accepted");
	chk_done_clears: assert property (desc_done_r |-> !desc_valid_r && bytes_left_r == 15'h0 ##1 !desc_done_r)
		else $error("valid kept after done");
	chk_token_map: assert property (txn_req_r |-> txn_r.pid == (img_r[42] ? ITD_PID_IN : ITD_PID_OUT))
		else $error("token wrong");
	chk_split_speed: assert property (txn_req_r |-> txn_r.speed ==
		(!img_r[46] ? ITD_SPD_HIGH : ((img_r[49:48] == 2'h2) ? ITD_SPD_LOW : ITD_SPD_FULL)))
		else $error("speed wrong");
	chk_idle_quiet: assert property (!desc_valid_r |-> !txn_req_r)
		else $error("traffic while not valid");
endmodule : itd_exec_checker

bind itd_exec itd_exec_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .desc_load(desc_load),
	.desc_in(desc_in), .txn_r(txn_r), .txn_req_r(txn_req_r), .desc_valid_r(desc_valid_r),
	.desc_done_r(desc_done_r), .desc_error_r(desc_error_r), .bytes_left_r(bytes_left_r));

// ---- tb/itd_engine_model.sv ----
// Packet engine model beyond the executor.
// Answers each request once, after lag cycles, with done or fatal.
`timescale 1ns/1ps
module itd_engine_model
	import itd_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         rst_n,
	input wire logic         txn_req_r,
	input itd_pkg::itd_txn_t txn_r,
	input wire logic         fail_next,
	input wire logic [3:0]   lag,
	output logic             txn_done,
	output logic             txn_fatal,
	output logic [10:0]      txn_xfer_bytes
);
	initial begin
		txn_done = 1'b0;
		txn_fatal = 1'b0;
		txn_xfer_bytes = 11'h7FF;
	end
	// Byte lines inverted after the answer, so no stale value lingers
	always @(posedge ref_clk) begin
		if (rst_n && txn_req_r === 1'b1) begin
			repeat (lag + 1) @(negedge ref_clk);
			txn_done = !fail_next;
			txn_fatal = fail_next;
			txn_xfer_bytes = txn_r.bytes;
			@(negedge ref_clk);
			txn_done = 1'b0;
			txn_fatal = 1'b0;
			txn_xfer_bytes = ~txn_r.bytes;
		end
	end
endmodule : itd_engine_model

// ---- tb/testbench.sv ----
// Self-checking bench for the descriptor executor.
// Loads driven at the falling edge; the engine model answers requests.
`timescale 1ns/1ps
module testbench;
	import itd_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        desc_load = 1'b0;
	logic        fail_next = 1'b0;
	logic [3:0]  lag = 4'h0;
	logic [63:0] desc_in = 64'h0;
	logic [7:0]  poll_in = 8'h00;
	logic [63:0] d;
	logic [6:0]  a;
	logic [3:0]  e;
	logic        tok;
	logic        txn_done, txn_fatal, txn_req_r, desc_valid_r, desc_done_r, desc_error_r;
	logic [10:0] txn_xfer_bytes;
	logic [14:0] bytes_left_r;
	itd_txn_t    txn_r;
	itd_txn_t    exp_q[$];
	int          fail_count = 0;
	int          comparisons = 0;
	// Clock
	always #4 ref_clk = ~ref_clk;
	itd_exec #(.UFRAME_CYC(1000)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .desc_load(desc_load),
		.desc_in(desc_in), .desc_poll_in(poll_in),
		.txn_done(txn_done), .txn_xfer_bytes(txn_xfer_bytes), .txn_fatal(txn_fatal), .txn_r(txn_r),
		.txn_req_r(txn_req_r), .desc_valid_r(desc_valid_r), .desc_done_r(desc_done_r),
		.desc_error_r(desc_error_r), .bytes_left_r(bytes_left_r));
	itd_engine_model u_eng (.ref_clk(ref_clk), .rst_n(rst_n), .txn_req_r(txn_req_r), .txn_r(txn_r),
		.fail_next(fail_next), .lag(lag), .txn_done(txn_done), .txn_fatal(txn_fatal),
		.txn_xfer_bytes(txn_xfer_bytes));
	task check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// Descriptor image; reserved bits set to ones, they must not matter
	function automatic logic [63:0] mk(input logic [14:0] n, input logic [2:0] sp, input logic [1:0] tt,
		input logic v);
		mk = 64'h0000_8000_6000_0006;
		mk[49:48] = sp[1:0];
		mk[46] = sp[2];
		mk[45:44] = tt;
		mk[42] = tok;
		mk[41:35] = a;
		mk[34:31] = e;
		mk[28:18] = 11'h00C;
		mk[17:3] = n;
		mk[0] = v;
	endfunction : mk
	task expect_txn(input logic [10:0] b, input itd_speed_t s);
		exp_q.push_back({d[41:35], d[34:31], d[42] ? ITD_PID_IN : ITD_PID_OUT, s, b});
	endtask : expect_txn
	// Load, then wait for done or error under a bound
	task run(input int limit, input logic ends);
		int i;
		desc_in = d;
		desc_load = 1'b1;
		@(negedge ref_clk);
		desc_load = 1'b0;
		for (i = 0; i < limit && desc_done_r !== 1'b1 && desc_error_r !== 1'b1; i++)
			@(negedge ref_clk);
		if (ends && i == limit) begin
			fail_count++;
			report_and_stop();
		end
	endtask : run
	// Each request is matched against the oldest note
	always @(negedge ref_clk) begin
		if (txn_req_r === 1'b1) begin
			if (exp_q.size() == 0)
				check(32'h1, 32'h0);
			else
				check(32'(txn_r), 32'(exp_q.pop_front()));
		end
	end
	initial begin
		void'($urandom(32'hE61315CF));
		a = 7'($urandom_range(127, 1));
		e = 4'($urandom);
		tok = 1'($urandom);
		lag = 4'($urandom);
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		d = mk(15'h0020, 3'h6, 2'h3, 1'b1);
		expect_txn(11'h00C, ITD_SPD_LOW);
		expect_txn(11'h00C, ITD_SPD_LOW);
		expect_txn(11'h008, ITD_SPD_LOW);
		run(30000, 1'b1);
		check(32'(desc_done_r), 32'h1);
		tok = !tok;
		d = mk(15'h0000, 3'h4, 2'h3, 1'b1);
		poll_in = 8'h08;
		expect_txn(11'h000, ITD_SPD_FULL);
		run(18000, 1'b1);
		check(32'(desc_done_r), 32'h1);
		poll_in = 8'h00;
		d = mk(15'h0020, 3'h0, 2'h3, 1'b0);
		run(9000, 1'b0);
		check(32'(desc_valid_r), 32'h0);
		fail_next = 1'b1;
		d = mk(15'h0040, 3'h0, 2'h3, 1'b1);
		expect_txn(11'h00C, ITD_SPD_HIGH);
		run(9000, 1'b1);
		check(32'({desc_valid_r, desc_error_r}), 32'h1);
		fail_next = 1'b0;
		d = mk(15'h0020, 3'h0, 2'h2, 1'b1);
		run(100, 1'b1);
		check(32'({desc_valid_r, desc_error_r}), 32'h1);
		d = mk(15'h1020, 3'h0, 2'h3, 1'b1);
		run(100, 1'b1);
		check(32'({desc_valid_r, desc_error_r}), 32'h1);
		check(32'(exp_q.size()), 32'h0);
		report_and_stop();
	end
endmodule : testbench
